// file: src/dprc_pkg.sv
// Purpose: constants for the two-port memory port controller
// Assumes: 250 MHz clk, one memory port driven from synchronous logic
// Notes: timing counts are cycles of clk
package dprc_pkg;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 18;
   localparam int BYTE_W = 9;
   localparam int FLAG_ADDR_W = 3;
   localparam int CLK_PERIOD_PS = 4000;
   // access time of the memory, ps
   localparam int ACCESS_PS = 15000;
   localparam int ACCESS_CYC = (ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [2:0] CNT_LOAD = 3'(ACCESS_CYC);
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_FLAG_READ = 2'h2;
   localparam logic [1:0] OP_FLAG_WRITE = 2'h3;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b11,
      ST_FINISH = 2'b10
   } dprc_state_e;
endpackage : dprc_pkg

// file: src/dprc_in_sync.sv
// Purpose: two-flop synchroniser for the memory data pins
// Assumes: pins change asynchronously to clk
// Notes: only the second stage is visible
`timescale 1ns/1ps
`default_nettype none
module dprc_in_sync (
   input wire logic clk, // clock
   input wire logic resetn, // async reset, low
   input wire logic [dprc_pkg::DATA_W-1:0] dIn, // raw pins
   output logic [dprc_pkg::DATA_W-1:0] dOut // synchronised
);
   import dprc_pkg::*;
   logic [DATA_W-1:0] meta_ff;
   logic [DATA_W-1:0] sync_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= dIn;
         sync_ff <= meta_ff;
      end
   end
   assign dOut = sync_ff;
endmodule : dprc_in_sync
`default_nettype wire

// file: src/dprc_port_ctrl.sv
// Purpose: bus master that drives one port of a two-port static memory
// Assumes: request held stable while reqValid and not reqReady
// Notes: one access at a time; flag writes commit on the rising write strobe
//
// Notes on behaviour
// [R01] write with only lower byte select stores low byte; upper lines left undriven
// [R02] upper-only write stores upper byte; both selects low stores both bytes
// [R03] flag read drives each byte group only when its select is held low
// [R04] flag read: chip deselected, flag enable, read, output enable and both selects low
// [R05] flag write: chip deselected, flag enable and lower select low, rising write strobe
// [R06] eight flags chosen by the three lowest address bits
// [R07] flag written from data bit zero, read back on every data line
// [R08] idle deselects port; array reads need output enable; never chip and flag together
`timescale 1ns/1ps
`default_nettype none
module dprc_port_ctrl (
   input wire logic clk, // clock
   input wire logic resetn, // async reset, low
   input wire logic reqValid, // request present
   output logic reqReady, // request taken
   input wire logic [1:0] reqOp, // operation code
   input wire logic [dprc_pkg::ADDR_W-1:0] reqAddr, // word or flag address
   input wire logic [dprc_pkg::DATA_W-1:0] reqWdata, // write data
   input wire logic [1:0] reqByteEn, // bit1 upper, bit0 lower
   output logic rspValid, // read data valid pulse
   output logic [dprc_pkg::DATA_W-1:0] rspRdata, // read data
   output logic selectLowActiveN, // chip enable 0, low active
   output logic selectHighActive, // chip enable 1, high active
   output logic flagAccessEnableN, // flag enable, low active
   output logic readWriteN, // high read, low write
   output logic outputEnableN, // output enable, low active
   output logic upperByteSelectN, // upper byte select, low active
   output logic lowerByteSelectN, // lower byte select, low active
   output logic [dprc_pkg::ADDR_W-1:0] memAddr, // address pins
   output logic [dprc_pkg::DATA_W-1:0] memDataOut, // data pins, out
   output logic [dprc_pkg::DATA_W-1:0] memDataOe, // data pin enables
   input wire logic [dprc_pkg::DATA_W-1:0] memDataIn // data pins, in
);
   import dprc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   dprc_state_e state_ff, nxt_state;
   logic [2:0] cnt_ff, nxt_cnt;
   logic [1:0] op_ff, nxt_op;
   logic [1:0] be_ff, nxt_be;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] wd_ff, nxt_wd;
   logic [DATA_W-1:0] rd_ff, nxt_rd;
   logic rv_ff, nxt_rv;
   logic [DATA_W-1:0] pinData;

   dprc_in_sync uSync (
      .clk(clk),
      .resetn(resetn),
      .dIn(memDataIn),
      .dOut(pinData)
   );

   function automatic logic isFlag(input logic [1:0] op);
      return op[1];
   endfunction : isFlag

   function automatic logic isWrite(input logic [1:0] op);
      return op[0];
   endfunction : isWrite

   assign reqReady = (state_ff == ST_IDLE);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_op = op_ff;
      nxt_be = be_ff;
      nxt_addr = addr_ff;
      nxt_wd = wd_ff;
      nxt_rd = rd_ff;
      nxt_rv = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (reqValid) begin
               nxt_op = reqOp;
               // flag accesses use only the three low address bits
               nxt_addr = isFlag(reqOp) ?
                  {{(ADDR_W-FLAG_ADDR_W){1'b0}}, reqAddr[FLAG_ADDR_W-1:0]} : reqAddr; // R06
               // a flag read drives both groups so the flag shows on every line
               nxt_be = (reqOp == OP_FLAG_READ) ? 2'b11 : // R04
                  (reqOp == OP_FLAG_WRITE) ? 2'b01 : reqByteEn; // R05
               nxt_wd = reqWdata;
               nxt_cnt = CNT_LOAD;
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            nxt_cnt = CNT_LOAD;
            nxt_state = ST_STROBE;
         end
         ST_STROBE: begin
            if (cnt_ff == 3'h0) begin
               // two extra cycles for the synchroniser before sampling
               nxt_state = ST_FINISH;
               nxt_cnt = 3'h2;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         ST_FINISH: begin
            if (isWrite(op_ff) || cnt_ff == 3'h0) begin
               nxt_state = ST_IDLE;
               if (!isWrite(op_ff)) begin
                  nxt_rd = pinData;
                  nxt_rv = 1'b1;
               end
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 3'h0;
         op_ff <= OP_READ;
         be_ff <= 2'h0;
         addr_ff <= '0;
         wd_ff <= '0;
         rd_ff <= '0;
         rv_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         op_ff <= nxt_op;
         be_ff <= nxt_be;
         addr_ff <= nxt_addr;
         wd_ff <= nxt_wd;
         rd_ff <= nxt_rd;
         rv_ff <= nxt_rv;
      end
   end

   assign rspValid = rv_ff;
   assign rspRdata = rd_ff;

   // ****************************************
   // pin drive
   // ****************************************
   logic busy;
   logic [DATA_W-1:0] nxt_pinOut, pinOut_ff;
   logic [DATA_W-1:0] nxt_pinOe, pinOe_ff;
   logic [6:0] nxt_ctl, ctl_ff;

   assign busy = (state_ff != ST_IDLE);

   always_comb begin
      // ctl = {sel0n, sel1, flagn, rwn, oen, upn, lon}; idle deselects
      nxt_ctl = 7'h5b; // R08
      nxt_pinOut = '0;
      nxt_pinOe = '0;
      if (busy && nxt_state != ST_IDLE) begin
         nxt_ctl[6] = isFlag(op_ff); // R08
         nxt_ctl[5] = 1'b1;
         nxt_ctl[4] = !isFlag(op_ff);
         nxt_ctl[3] = !(isWrite(op_ff) && nxt_state == ST_STROBE); // R05
         nxt_ctl[2] = isWrite(op_ff); // R08
         nxt_ctl[1] = !be_ff[1]; // R02 R03
         nxt_ctl[0] = !be_ff[0]; // R01 R03
         if (isWrite(op_ff)) begin
            if (isFlag(op_ff)) begin
               nxt_pinOut = {{(DATA_W-1){1'b0}}, wd_ff[0]}; // R07
               nxt_pinOe = {{(DATA_W-1){1'b0}}, 1'b1};
            end else begin
               nxt_pinOut = wd_ff;
               nxt_pinOe = {{BYTE_W{be_ff[1]}}, {BYTE_W{be_ff[0]}}}; // R01 R02
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_ff <= 7'h5b;
         pinOut_ff <= '0;
         pinOe_ff <= '0;
      end else begin
         ctl_ff <= nxt_ctl;
         pinOut_ff <= nxt_pinOut;
         pinOe_ff <= nxt_pinOe;
      end
   end

   assign selectLowActiveN = ctl_ff[6];
   assign selectHighActive = ctl_ff[5];
   assign flagAccessEnableN = ctl_ff[4];
   assign readWriteN = ctl_ff[3];
   assign outputEnableN = ctl_ff[2];
   assign upperByteSelectN = ctl_ff[1];
   assign lowerByteSelectN = ctl_ff[0];
   assign memAddr = addr_ff;
   assign memDataOut = pinOut_ff;
   assign memDataOe = pinOe_ff;

   // ****************************************
   // checks
   // ****************************************
   wire chipSel = !selectLowActiveN && selectHighActive;
   sequence sFlagWrite;
      !flagAccessEnableN && !readWriteN;
   endsequence
   sequence sFlagCommit;
      !flagAccessEnableN && readWriteN;
   endsequence

   AST_NO_SEM_WITH_CE: assert property (@(posedge clk) disable iff (!resetn) // R08
      !(chipSel && !flagAccessEnableN)) else $error("chip and flag enables both active");
   AST_IDLE_DESEL: assert property (@(posedge clk) disable iff (!resetn) // R08
      $rose(reqReady) |-> selectLowActiveN && flagAccessEnableN && memDataOe == '0)
      else $error("port not deselected when idle");
   AST_LOW_ONLY: assert property (@(posedge clk) disable iff (!resetn) // R01
      chipSel && !readWriteN && !lowerByteSelectN && upperByteSelectN |->
      memDataOe[17:9] == '0 && memDataOe[8:0] == '1) else $error("low byte write drive wrong");
   AST_UP_ONLY: assert property (@(posedge clk) disable iff (!resetn) // R02
      chipSel && !readWriteN && lowerByteSelectN && !upperByteSelectN |->
      memDataOe[8:0] == '0 && memDataOe[17:9] == '1) else $error("upper byte write drive wrong");
   AST_FLAG_READ: assert property (@(posedge clk) disable iff (!resetn) // R04
      !flagAccessEnableN && readWriteN && outputEnableN == 1'b0 |->
      !upperByteSelectN && !lowerByteSelectN && memDataOe == '0)
      else $error("flag read pins wrong");
   AST_FLAG_BIT0: assert property (@(posedge clk) disable iff (!resetn) // R07
      !flagAccessEnableN && memDataOe != '0 |-> memDataOe[DATA_W-1:1] == '0)
      else $error("flag write drives more than bit zero");
   AST_FLAG_EDGE: assert property (@(posedge clk) disable iff (!resetn) // R05
      sFlagWrite ##1 sFlagCommit |-> !lowerByteSelectN && memDataOe[0])
      else $error("flag write edge without lower select");
   AST_FLAG_ADDR: assert property (@(posedge clk) disable iff (!resetn) // R06
      !flagAccessEnableN |-> memAddr[ADDR_W-1:FLAG_ADDR_W] == '0)
      else $error("flag address out of range");
   // the rising write strobe also shows chip selected with rwn high, so only
   // cycles with no data drive count as array reads
   AST_READ_OE: assert property (@(posedge clk) disable iff (!resetn) // R08
      chipSel && readWriteN && memDataOe == '0 |-> !outputEnableN ##[1:12] rspValid)
      else $error("read without output enable or answer");
endmodule : dprc_port_ctrl
`default_nettype wire

// file: verification/dprc_mem_model.sv
// Purpose: behavioural model of one port of the two-port memory
// Assumes: pins come from the port controller
// Notes: undriven data pins show a pattern that flips each clk
`timescale 1ns/1ps
`default_nettype none
module dprc_mem_model (
   input wire logic clk, // pattern clock
   input wire logic slow, // long access delay
   input wire logic selectLowActiveN, // enable 0
   input wire logic selectHighActive, // enable 1
   input wire logic flagAccessEnableN, // flag enable
   input wire logic readWriteN, // high read
   input wire logic outputEnableN, // output enable
   input wire logic upperByteSelectN, // upper select
   input wire logic lowerByteSelectN, // lower select
   input wire logic [dprc_pkg::ADDR_W-1:0] memAddr, // address
   input wire logic [dprc_pkg::DATA_W-1:0] memDataOut, // data from controller
   input wire logic [dprc_pkg::DATA_W-1:0] memDataOe, // controller drives
   output logic [dprc_pkg::DATA_W-1:0] memDrv, // pins as seen from here
   output logic illegal // sticky fault flag
);
   import dprc_pkg::*;
   // ****************
   // storage
   // ****************
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [7:0] flags;
   logic [DATA_W-1:0] junk, val, en, w;
   wire logic chipOn;
   assign chipOn = !selectLowActiveN && selectHighActive;
   initial begin
      flags = 8'h00;
      junk = 18'h2_aaaa;
      illegal = 1'b0;
   end
   always @(posedge clk) junk <= ~junk;
   // writes commit on the rising strobe
   always @(posedge readWriteN) begin
      if (chipOn && flagAccessEnableN) begin
         w = mem.exists(memAddr) ? mem[memAddr] : ~memDataOut;
         if (!lowerByteSelectN) w[BYTE_W-1:0] = memDataOut[BYTE_W-1:0];
         if (!upperByteSelectN) w[DATA_W-1:BYTE_W] = memDataOut[DATA_W-1:BYTE_W];
         mem[memAddr] = w;
      end else if (!chipOn && !flagAccessEnableN && !lowerByteSelectN) begin
         flags[memAddr[2:0]] = memDataOut[0];
      end
   end
   always @(junk or memAddr or readWriteN or outputEnableN or flagAccessEnableN or chipOn
         or upperByteSelectN or lowerByteSelectN) begin
      val = '0;
      en = {{BYTE_W{!upperByteSelectN}}, {BYTE_W{!lowerByteSelectN}}};
      if (chipOn && flagAccessEnableN && readWriteN && !outputEnableN) begin
         val = mem.exists(memAddr) ? mem[memAddr] : junk;
      end else if (!chipOn && !flagAccessEnableN && readWriteN && !outputEnableN) begin
         val = {DATA_W{flags[memAddr[2:0]]}};
      end else begin
         en = '0;
      end
   end
   // slow answers still land inside the controller's access window
   always @(val or en or junk) memDrv <= #(slow ? 12 : 2) (val & en) | (junk & ~en);
   // sampled mid-cycle so pin updates at the rising edge cannot race the check
   always @(negedge clk) begin
      if ((chipOn && !flagAccessEnableN) || (|(memDataOe & en))) illegal <= 1'b1;
   end
endmodule : dprc_mem_model
`default_nettype wire

// file: verification/test_dual_port_ram_port_access.sv
// Purpose: self-checking bench for the memory port controller
// Assumes: memory model on the far side of the pins
// Notes: unselected bytes read back as junk, so they are masked
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_ram_port_access;
   import dprc_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, reqValid = 1'b0, slow = 1'b0;
   logic [1:0] reqOp = 2'h0, reqByteEn = 2'h0;
   logic [ADDR_W-1:0] reqAddr = 18'h0_0000, memAddr, adr[4];
   logic [DATA_W-1:0] reqWdata = 18'h0_0000, rspRdata, memDataOut, memDataOe, memDataIn, memDrv;
   logic reqReady, rspValid, selectLowActiveN, selectHighActive, flagAccessEnableN;
   logic readWriteN, outputEnableN, upperByteSelectN, lowerByteSelectN, illegal;
   logic [DATA_W-1:0] expQ[$], maskQ[$], shadow[logic [ADDR_W-1:0]], e, m;
   logic [7:0] flagExp = 8'h00;
   logic [31:0] seed, r, q;
   int failures = 0, numChecks = 0;
   assign memDataIn = (memDataOut & memDataOe) | (memDrv & ~memDataOe);
   always #2 clk = ~clk;
   dprc_port_ctrl u_dut (.clk, .resetn, .reqValid, .reqReady, .reqOp, .reqAddr, .reqWdata,
      .reqByteEn, .rspValid, .rspRdata, .selectLowActiveN, .selectHighActive,
      .flagAccessEnableN, .readWriteN, .outputEnableN, .upperByteSelectN,
      .lowerByteSelectN, .memAddr, .memDataOut, .memDataOe, .memDataIn);
   dprc_mem_model u_mem (.clk, .slow, .selectLowActiveN, .selectHighActive,
      .flagAccessEnableN, .readWriteN, .outputEnableN, .upperByteSelectN,
      .lowerByteSelectN, .memAddr, .memDataOut, .memDataOe, .memDrv, .illegal);
   // ****************
   // tasks
   // ****************
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic access(input logic [1:0] op, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d, input logic [1:0] be);
      int n;
      logic [DATA_W-1:0] v;
      n = 0;
      v = shadow.exists(a) ? shadow[a] : 18'h0_0000;
      @(posedge clk);
      #1;
      reqValid = 1'b1;
      reqOp = op;
      reqAddr = a;
      reqWdata = d;
      reqByteEn = be;
      while (reqReady !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      reqValid = 1'b0;
      if (n >= 100) begin
         failures++;
         complete_run();
      end
      case (op)
         OP_WRITE: begin
            if (be[0]) v[BYTE_W-1:0] = d[BYTE_W-1:0];
            if (be[1]) v[DATA_W-1:BYTE_W] = d[DATA_W-1:BYTE_W];
            shadow[a] = v;
         end
         OP_READ: begin
            expQ.push_back(v);
            maskQ.push_back({{BYTE_W{be[1]}}, {BYTE_W{be[0]}}});
         end
         OP_FLAG_WRITE: flagExp[a[2:0]] = d[0];
         default: begin
            expQ.push_back({DATA_W{flagExp[a[2:0]]}});
            maskQ.push_back({DATA_W{1'b1}});
         end
      endcase
   endtask : access
   always @(negedge clk) begin
      if (rspValid === 1'b1) begin
         e = expQ.size() > 0 ? expQ.pop_front() : ~rspRdata;
         m = maskQ.size() > 0 ? maskQ.pop_front() : {DATA_W{1'b1}};
         check(rspRdata & m, e & m);
      end
   end
   initial begin
      seed = 32'h96f7_8ff9;
      repeat (12) @(posedge clk);
      #1;
      // idle pattern of the controller: first enable high, second low, no drive
      check(18'({selectLowActiveN, selectHighActive, flagAccessEnableN, readWriteN,
         outputEnableN, upperByteSelectN, lowerByteSelectN}), 18'h0_005b);
      check(memDataOe, 18'h0_0000);
      resetn = 1'b1;
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         q = $random(seed);
         adr[i] = r[ADDR_W-1:0];
         slow = i[0];
         access(OP_WRITE, adr[i], ~q[DATA_W-1:0], 2'h3);
         access(OP_WRITE, adr[i], r[DATA_W-1:0], 2'h1);
         access(OP_READ, adr[i], 18'h0_0000, 2'h3);
         access(OP_WRITE, adr[i], q[DATA_W-1:0], 2'h2);
         access(OP_READ, adr[i], 18'h0_0000, 2'h3);
      end
      $display("byte write test done");
      for (int k = 0; k < 40; k++) begin
         r = $random(seed);
         q = $random(seed);
         slow = r[31];
         access({1'b0, r[30]}, adr[r[29:28]], q[DATA_W-1:0], r[1:0] == 2'h0 ? 2'h3 : r[1:0]);
      end
      $display("random array test done");
      for (int f = 0; f < 24; f++) begin
         r = $random(seed);
         slow = r[31];
         if (f < 16) access(OP_FLAG_WRITE, {r[30:16], 3'(f)}, r[DATA_W-1:0], r[1:0]);
         access(OP_FLAG_READ, {r[15:1], 3'(f)}, 18'h0_0000, r[3:2]);
      end
      access(OP_READ, adr[0], 18'h0_0000, 2'h3);
      $display("flag test done");
      for (int n = 0; n < 100 && expQ.size() > 0; n++) @(posedge clk);
      check(18'(expQ.size()), 18'h0_0000);
      check(18'(illegal), 18'h0_0000);
      complete_run();
   end
endmodule : test_dual_port_ram_port_access
`default_nettype wire
